// ===== logic/eph_port_hs.sv
// Purpose: host side handshake of a parallel port: compatibility fifo mode and ecp forward/reverse
// Assumes: one clock clk_sys at 50 MHz, peripheral inputs asynchronous
// Notes:   mode and driver type change only while the link is idle
`timescale 1ns/10ps
module eph_port_hs (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic [2:0] mode_sel,
    input  wire logic       reverse_req,
    input  wire logic       transfer_direction_bit,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ack_q,
    input  wire logic       rx_room,
    output logic            rx_valid_q,
    output logic [7:0]      rx_data_q,
    input  wire logic       busy_in,
    input  wire logic       nack_in,
    input  wire logic       nfault_in,
    input  wire logic [7:0] pd_in,
    output logic [7:0]      pd_q,
    output logic            pd_oe_q,
    output logic            nstrobe_q,
    output logic            nstrobe_oe_q,
    output logic            nautofd_q,
    output logic            nautofd_oe_q,
    output logic            nwrite_q,
    output logic            totem_q,
    output logic            reverse_q,
    output logic            periph_req_q
);
    localparam int TW = eph_pkg::TMR_W;

    initial begin
        if (eph_pkg::T_SETUP_CYC > 31 || eph_pkg::T_STROBE_CYC > 31 || eph_pkg::T_HOLD_CYC > 31
            || eph_pkg::ECP_SETUP_CYC > 31) $error("eph_port_hs: timer too narrow");
    end

    logic [2:0] filt_w;
    logic [2:0] raw_w;
    assign raw_w = {nfault_in, nack_in, busy_in};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_in
            eph_filt #(
                .FILT    (eph_pkg::FILT_CYC),
                .RST_VAL (eph_pkg::IN_RST_VAL[gi])
            ) u_filt (
                .clk_sys (clk_sys),
                .rst_n   (rst_n),
                .raw     (raw_w[gi]),
                .filt_q  (filt_w[gi])
            );
        end
    endgenerate

    wire busy_f   = filt_w[eph_pkg::IN_BUSY];
    wire nack_f   = filt_w[eph_pkg::IN_NACK];
    wire nfault_f = filt_w[eph_pkg::IN_NFAULT];
    wire is_fifo  = mode_sel == eph_pkg::MODE_FIFO;
    wire is_ecp   = mode_sel == eph_pkg::MODE_ECP;

    eph_pkg::eph_state_t st_q;
    eph_pkg::eph_state_t st_d;
    logic [TW-1:0]       tmr_q;
    logic [TW-1:0]       tmr_d;
    logic                stb_d;
    logic                afd_d;
    logic                drv_d;
    logic [7:0]          pd_d;
    logic                take;
    logic                cap;
    wire                 tmr_done = tmr_q == '0;

    function automatic logic in_rev(input eph_pkg::eph_state_t s);
        return s == eph_pkg::ST_R_IDLE || s == eph_pkg::ST_R_HI;
    endfunction

    always_comb begin
        st_d  = st_q;
        tmr_d = tmr_done ? tmr_q : tmr_q - 1'b1;
        stb_d = nstrobe_q;
        afd_d = nautofd_q;
        drv_d = totem_q;
        pd_d  = pd_q;
        take  = 1'b0;
        cap   = 1'b0;
        case (st_q)
            eph_pkg::ST_IDLE: begin
                drv_d = is_ecp;
                if (is_fifo && tx_valid && !busy_f) begin
                    take  = 1'b1;
                    pd_d  = tx_data;
                    tmr_d = TW'(eph_pkg::T_SETUP_CYC - 1);
                    st_d  = eph_pkg::ST_C_SET;
                end else if (is_ecp && totem_q) begin
                    st_d = eph_pkg::ST_F_IDLE;
                end
            end
            eph_pkg::ST_C_SET: begin
                if (tmr_done) begin
                    stb_d = 1'b0;
                    tmr_d = TW'(eph_pkg::T_STROBE_CYC - 1);
                    st_d  = eph_pkg::ST_C_STB;
                end
            end
            eph_pkg::ST_C_STB: begin
                if (tmr_done) begin
                    stb_d = 1'b1;
                    tmr_d = TW'(eph_pkg::T_HOLD_CYC - 1);
                    st_d  = eph_pkg::ST_C_HOLD;
                end
            end
            eph_pkg::ST_C_HOLD: begin
                // data is only replaced by the next take, so it stays put if nothing is pending
                if (tmr_done) st_d = eph_pkg::ST_IDLE;
            end
            eph_pkg::ST_F_IDLE: begin
                if (!is_ecp) begin
                    st_d = eph_pkg::ST_IDLE;
                end else if (reverse_req && !busy_f) begin
                    afd_d = 1'b0;
                    st_d  = eph_pkg::ST_R_IDLE;
                end else if (tx_valid && !busy_f) begin
                    take  = 1'b1;
                    pd_d  = tx_data;
                    tmr_d = TW'(eph_pkg::ECP_SETUP_CYC - 1);
                    st_d  = eph_pkg::ST_F_SET;
                end
            end
            eph_pkg::ST_F_SET: begin
                if (tmr_done) begin
                    stb_d = 1'b0;
                    st_d  = eph_pkg::ST_F_HI;
                end
            end
            eph_pkg::ST_F_HI: begin
                if (busy_f) begin
                    stb_d = 1'b1;
                    st_d  = eph_pkg::ST_F_LO;
                end
            end
            eph_pkg::ST_F_LO: begin
                if (!busy_f) st_d = eph_pkg::ST_F_IDLE;
            end
            eph_pkg::ST_R_IDLE: begin
                if (!reverse_req && nack_f) begin
                    afd_d = 1'b1;
                    st_d  = eph_pkg::ST_F_IDLE;
                end else if (!nack_f && rx_room) begin
                    cap   = 1'b1;
                    afd_d = 1'b1;
                    st_d  = eph_pkg::ST_R_HI;
                end
            end
            eph_pkg::ST_R_HI: begin
                if (nack_f) begin
                    afd_d = 1'b0;
                    st_d  = eph_pkg::ST_R_IDLE;
                end
            end
            default: begin
                st_d  = eph_pkg::ST_IDLE;
                stb_d = 1'b1;
                afd_d = 1'b1;
            end
        endcase
    end

    // open-collector only pulls low; the level never changes with the driver type
    wire stb_oe_d = drv_d | ~stb_d;
    wire afd_oe_d = drv_d | ~afd_d;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q         <= eph_pkg::ST_IDLE;
            tmr_q        <= '0;
            nstrobe_q    <= 1'b1;
            nstrobe_oe_q <= 1'b0;
            nautofd_q    <= 1'b1;
            nautofd_oe_q <= 1'b0;
            totem_q      <= 1'b0;
            pd_q         <= 8'h00;
            pd_oe_q      <= 1'b0;
        end else begin
            st_q         <= st_d;
            tmr_q        <= tmr_d;
            nstrobe_q    <= stb_d;
            nstrobe_oe_q <= stb_oe_d;
            nautofd_q    <= afd_d;
            nautofd_oe_q <= afd_oe_d;
            totem_q      <= drv_d;
            pd_q         <= pd_d;
            pd_oe_q      <= !in_rev(st_d);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_ack_q     <= 1'b0;
            rx_valid_q   <= 1'b0;
            rx_data_q    <= 8'h00;
            nwrite_q     <= 1'b1;
            reverse_q    <= 1'b0;
            periph_req_q <= 1'b0;
        end else begin
            tx_ack_q     <= take;
            rx_valid_q   <= cap;
            rx_data_q    <= cap ? pd_in : rx_data_q;
            nwrite_q     <= transfer_direction_bit;
            reverse_q    <= in_rev(st_d);
            periph_req_q <= !nfault_f;
        end
    end

    // helper ages for the timing checks, saturating
    logic [5:0] pd_age_q;
    logic [5:0] hi_age_q;
    logic [5:0] lo_age_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pd_age_q <= '0;
            hi_age_q <= '0;
            lo_age_q <= '0;
        end else begin
            pd_age_q <= (pd_d != pd_q) ? '0 : (&pd_age_q ? pd_age_q : pd_age_q + 1'b1);
            hi_age_q <= !stb_d ? '0 : (&hi_age_q ? hi_age_q : hi_age_q + 1'b1);
            lo_age_q <= stb_d ? '0 : (&lo_age_q ? lo_age_q : lo_age_q + 1'b1);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    fifo_setup_a: assert property ($fell(nstrobe_q) && !totem_q |-> $past(pd_age_q) >= 6'(eph_pkg::T_SETUP_CYC - 1))
        else $error("fifo data setup too short");
    fifo_pulse_a: assert property ($rose(nstrobe_q) && !totem_q |-> $past(lo_age_q) >= 6'(eph_pkg::T_STROBE_CYC - 1))
        else $error("fifo strobe pulse too short");
    fifo_hold_a: assert property ($changed(pd_q) && !totem_q |-> $past(hi_age_q) >= 6'(eph_pkg::T_HOLD_CYC))
        else $error("fifo data hold too short");
    fifo_busy_a: assert property (tx_ack_q && !totem_q |-> !$past(busy_f))
        else $error("fifo byte started while busy");
    ecp_setup_a: assert property ($fell(nstrobe_q) && totem_q |-> $past(pd_age_q) >= 6'(eph_pkg::ECP_SETUP_CYC - 1))
        else $error("ecp data setup too short");
    fwd_idle_a: assert property (st_q == eph_pkg::ST_F_IDLE |-> nstrobe_q)
        else $error("strobe low in forward idle");
    rev_idle_a: assert property (st_q == eph_pkg::ST_R_IDLE |-> !nautofd_q && !pd_oe_q)
        else $error("nautofd high in reverse idle");
    fwd_entry_a: assert property ($changed(st_q) && st_q == eph_pkg::ST_F_SET |-> $past(st_q) == eph_pkg::ST_F_IDLE)
        else $error("forward transfer not from forward idle");
    fwd_release_a: assert property ($rose(nstrobe_q) && totem_q |-> $past(busy_f, 1))
        else $error("strobe released before busy acknowledge");
    rev_ack_a: assert property ($rose(nautofd_q) && reverse_q |-> rx_valid_q ##1 !rx_valid_q)
        else $error("reverse byte not captured on acknowledge");
    drv_oe_a: assert property (totem_q |-> nstrobe_oe_q && nautofd_oe_q)
        else $error("totem-pole driver not enabled in ecp");
    drv_oc_a: assert property (!totem_q |-> nstrobe_oe_q == !nstrobe_q)
        else $error("open-collector drives high");

    fifo_byte_c: cover property (tx_ack_q && !totem_q ##[1:100] $rose(nstrobe_q));
    ecp_fwd_c: cover property ($fell(nstrobe_q) && totem_q ##[1:100] st_q == eph_pkg::ST_F_IDLE);
    ecp_rev_c: cover property (rx_valid_q ##[1:100] st_q == eph_pkg::ST_R_IDLE);
    turn_c: cover property ($rose(reverse_q) ##[1:200] $fell(reverse_q));
endmodule // eph_port_hs

// ===== logic/eph_pkg.sv
// Purpose: shared constants for the parallel port handshake block
// Assumes: clk_sys at 50 MHz
// Notes:   times in ns as printed, cycle counts derived from them
package eph_pkg;
    localparam int CLK_NS        = 20;
    // compatibility fifo strobe timing
    localparam int T_SETUP_NS    = 600;
    localparam int T_STROBE_NS   = 600;
    localparam int T_HOLD_NS     = 450;
    // minimum stable time before a peripheral input counts as changed
    localparam int FILT_NS       = 75;
    // ecp forward setup is three cable round trips
    localparam int ROUNDTRIPS    = 3;
    localparam int ROUNDTRIP_NS  = 50;
    localparam int ECP_SETUP_NS  = ROUNDTRIPS * ROUNDTRIP_NS;

    // least times round up
    localparam int T_SETUP_CYC   = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_STROBE_CYC  = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_HOLD_CYC    = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int FILT_CYC      = (FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int ECP_SETUP_CYC = (ECP_SETUP_NS + CLK_NS - 1) / CLK_NS;

    localparam int TMR_W         = 5;
    localparam int FILT_W        = 3;

    // mode select codes
    localparam logic [2:0] MODE_FIFO = 3'h5;
    localparam logic [2:0] MODE_ECP  = 3'h3;

    // filtered input indices and their levels at rest
    localparam int IN_BUSY   = 0;
    localparam int IN_NACK   = 1;
    localparam int IN_NFAULT = 2;
    localparam logic [2:0] IN_RST_VAL = 3'h6;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0000,
        ST_C_SET  = 4'b0001,
        ST_C_STB  = 4'b0010,
        ST_C_HOLD = 4'b0011,
        ST_F_IDLE = 4'b0100,
        ST_F_SET  = 4'b0101,
        ST_F_HI   = 4'b0110,
        ST_F_LO   = 4'b0111,
        ST_R_IDLE = 4'b1000,
        ST_R_HI   = 4'b1001
    } eph_state_t;
endpackage

// ===== logic/eph_filt.sv
// Purpose: two-flop synchroniser and stability filter for one cable input
// Assumes: raw input is asynchronous to clk_sys
// Notes:   output moves only after the synchronised level differs for FILT cycles
`timescale 1ns/10ps
module eph_filt #(
    parameter int   FILT    = eph_pkg::FILT_CYC,
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic raw,
    output logic      filt_q
);
    logic                       sync1_q;
    logic                       sync2_q;
    logic [eph_pkg::FILT_W-1:0] cnt_q;
    wire                        differs  = sync2_q != filt_q;
    wire                        settled  = cnt_q == eph_pkg::FILT_W'(FILT - 1);

    initial begin
        if (FILT < 1 || FILT > 7) $error("eph_filt: FILT out of range");
    end

    // first flop feeds only the second flop
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= RST_VAL;
            sync2_q <= RST_VAL;
        end else begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
        end
    end

    // ringing restarts the count, so a glitch never reaches the handshake
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            filt_q <= RST_VAL;
        end else if (!differs) begin
            cnt_q <= '0;
        end else if (settled) begin
            cnt_q  <= '0;
            filt_q <= sync2_q;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    filt_stable_a: assert property ($changed(filt_q) |-> $past(cnt_q) == eph_pkg::FILT_W'(FILT - 1))
        else $error("filter output changed before input was stable");
    sync_path_a: assert property ($changed(filt_q) |-> filt_q == $past(sync2_q))
        else $error("filter output not taken from synchroniser");
endmodule // eph_filt

// ===== dv/eph_periph_model.sv
// Purpose: behavioural peripheral on the far side of the parallel port cable
// Assumes: it sees the resolved cable levels, pull-ups included
// Notes:   slow stretches every reply so long busy and nack phases get exercised
`timescale 1ns/10ps
module eph_periph_model (
    input  wire logic       clk_sys,
    input  wire logic       nstrobe_w,
    input  wire logic       nautofd_w,
    input  wire logic       rev_en,
    input  wire logic       slow,
    input  wire logic [7:0] rev_byte,
    output logic            busy,
    output logic            nack,
    output logic [7:0]      pd_out
);
    task automatic lag;
        repeat (slow ? 12 : 3) @(posedge clk_sys);
    endtask
    initial begin
        busy   = 1'b0;
        nack   = 1'b1;
        pd_out = 8'h00;
        forever begin
            @(posedge clk_sys);
            if (!nstrobe_w) begin
                lag();
                busy <= 1'b1;
                while (!nstrobe_w) @(posedge clk_sys);
                lag();
                busy <= 1'b0;
            end else if (rev_en && !nautofd_w) begin
                pd_out <= rev_byte;
                // data settles before nack falls
                lag();
                nack <= 1'b0;
                while (!nautofd_w) @(posedge clk_sys);
                lag();
                nack <= 1'b1;
                while (nautofd_w) @(posedge clk_sys);
                // released data lines must not keep showing the old byte
                pd_out <= ~rev_byte;
            end
        end
    end
endmodule // eph_periph_model

// ===== dv/tb_top.sv
// Purpose: self-checking bench for the parallel port handshake block
// Assumes: clk_sys 50 MHz, a behavioural peripheral on the cable side
// Notes:   open-collector lines resolve through a pull-up to high
`timescale 1ns/10ps
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED t=%0t %s", $time, m); end end
module tb_top;
    logic clk_sys, rst_n, reverse_req, transfer_direction_bit, tx_valid, rx_room;
    logic [2:0] mode_sel;
    logic [7:0] tx_data, rev_byte, rx_data_q, pd_q, pd_out, pd_in;
    logic tx_ack_q, rx_valid_q, pd_oe_q, nstrobe_q, nstrobe_oe_q, nautofd_q, nautofd_oe_q;
    logic nwrite_q, totem_q, reverse_q, periph_req_q, busy, nack, nfault, rev_en, slow;
    wire  nstrobe_w = nstrobe_oe_q ? nstrobe_q : 1'b1;
    wire  nautofd_w = nautofd_oe_q ? nautofd_q : 1'b1;
    int   mismatches = 0, check_count = 0, cyc = 0, n, busy_lo;
    assign pd_in = pd_oe_q ? pd_q : pd_out;

    eph_port_hs uut (.clk_sys(clk_sys), .rst_n(rst_n), .mode_sel(mode_sel), .reverse_req(reverse_req),
        .transfer_direction_bit(transfer_direction_bit), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ack_q(tx_ack_q), .rx_room(rx_room), .rx_valid_q(rx_valid_q), .rx_data_q(rx_data_q),
        .busy_in(busy), .nack_in(nack), .nfault_in(nfault), .pd_in(pd_in), .pd_q(pd_q), .pd_oe_q(pd_oe_q),
        .nstrobe_q(nstrobe_q), .nstrobe_oe_q(nstrobe_oe_q), .nautofd_q(nautofd_q),
        .nautofd_oe_q(nautofd_oe_q), .nwrite_q(nwrite_q), .totem_q(totem_q), .reverse_q(reverse_q),
        .periph_req_q(periph_req_q));
    eph_periph_model peri (.clk_sys(clk_sys), .nstrobe_w(nstrobe_w), .nautofd_w(nautofd_w),
        .rev_en(rev_en), .slow(slow), .rev_byte(rev_byte), .busy(busy), .nack(nack), .pd_out(pd_out));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // busy_lo counts how long the peripheral has shown not-busy
    always @(posedge clk_sys) begin
        cyc++;
        busy_lo = busy ? 0 : busy_lo + 1;
        if (cyc == 30000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tk;
        @(posedge clk_sys);
        #1;
    endtask
    // bounded wait on a level, returns the cycles spent
    `define WAITF(c) begin n = 0; while (!(c) && n < 3000) begin tk(); n++; end \
        `CHK((c), 1'b1, "wait expired") end

    task automatic t_reset(input logic oe_exp);
        `CHK({nstrobe_q, nstrobe_oe_q, nautofd_q, nautofd_oe_q, pd_oe_q}, {4'ha, oe_exp}, "idle controls")
        `CHK({nwrite_q, totem_q, reverse_q, periph_req_q, tx_ack_q, rx_valid_q}, 6'h20, "idle flags")
        $display("test reset done");
    endtask
    task automatic t_dir;
        @(posedge clk_sys) transfer_direction_bit <= 1'b0;
        repeat (3) tk();
        `CHK(nwrite_q, 1'b0, "write direction")
        @(posedge clk_sys) transfer_direction_bit <= 1'b1;
        repeat (3) tk();
        `CHK(nwrite_q, 1'b1, "read direction")
        @(posedge clk_sys) tx_valid <= 1'b1;
        repeat (40) begin
            tk();
            `CHK(tx_ack_q, 1'b0, "no transfer in idle mode")
        end
        @(posedge clk_sys) tx_valid <= 1'b0;
        $display("test dir done");
    endtask
    task automatic t_fifo;
        int k;
        @(posedge clk_sys) begin mode_sel <= eph_pkg::MODE_FIFO; slow <= 1'b1; tx_data <= 8'ha5; tx_valid <= 1'b1; end
        `WAITF(tx_ack_q)
        @(posedge clk_sys) tx_data <= 8'h3c;
        tk();
        `CHK(pd_q, 8'ha5, "fifo data")
        `WAITF(!nstrobe_q)
        // data was already out two cycles before the wait started
        `CHK(n + 2 >= eph_pkg::T_SETUP_CYC, 1'b1, "fifo data setup")
        `CHK({nstrobe_oe_q, totem_q}, 2'b10, "open collector low")
        `WAITF(nstrobe_q)
        `CHK(n >= eph_pkg::T_STROBE_CYC - 1, 1'b1, "fifo strobe width")
        `CHK(nstrobe_oe_q, 1'b0, "open collector released")
        for (k = 0; k < eph_pkg::T_HOLD_CYC; k++) begin
            `CHK(pd_q, 8'ha5, "fifo data hold")
            tk();
        end
        `WAITF(tx_ack_q)
        `CHK(busy_lo >= 4, 1'b1, "next byte paced by busy")
        @(posedge clk_sys) tx_valid <= 1'b0;
        repeat (300) tk();
        `CHK(pd_q, 8'h3c, "data held with nothing pending")
        @(posedge clk_sys) begin mode_sel <= 3'h0; slow <= 1'b0; end
        $display("test fifo done");
    endtask
    task automatic t_ecp_fwd;
        @(posedge clk_sys) begin mode_sel <= eph_pkg::MODE_ECP; tx_data <= 8'hb1; tx_valid <= 1'b1; end
        `WAITF(tx_ack_q)
        @(posedge clk_sys) tx_data <= 8'h4e;
        `CHK(totem_q, 1'b1, "ecp totem drive")
        `WAITF(!nstrobe_q)
        `CHK(n >= eph_pkg::ECP_SETUP_CYC - 1, 1'b1, "ecp data setup")
        `CHK({pd_q, nstrobe_oe_q}, 9'h163, "ecp data driven")
        `WAITF(busy)
        tk();
        `CHK(nstrobe_q, 1'b0, "strobe waits for filtered busy")
        `WAITF(nstrobe_q)
        `CHK(busy, 1'b1, "strobe rises on busy")
        `WAITF(tx_ack_q)
        `CHK(busy_lo >= 4, 1'b1, "next byte only from idle")
        @(posedge clk_sys) tx_valid <= 1'b0;
        `WAITF(!nstrobe_q)
        `CHK(pd_q, 8'h4e, "second ecp byte")
        `WAITF(!busy && nstrobe_q)
        repeat (20) tk();
        `CHK({nstrobe_q, nautofd_q, busy}, 3'b110, "forward idle levels")
        $display("test ecp forward done");
    endtask
    task automatic t_ecp_rev;
        @(posedge clk_sys) begin reverse_req <= 1'b1; rx_room <= 1'b0; rev_byte <= 8'h5a; rev_en <= 1'b1; end
        `WAITF(reverse_q)
        `CHK({nautofd_q, pd_oe_q}, 2'b00, "reverse idle levels")
        repeat (60) begin
            tk();
            `CHK({rx_valid_q, nautofd_w}, 2'b00, "stall holds nautofd low")
        end
        `CHK(nack, 1'b0, "peripheral offered a byte")
        @(posedge clk_sys) rx_room <= 1'b1;
        `WAITF(rx_valid_q)
        `CHK({rx_data_q, nautofd_q}, 9'h0b5, "reverse byte taken")
        @(posedge clk_sys) rev_byte <= 8'hc3;
        `WAITF(!nautofd_q)
        `CHK(nack, 1'b1, "nautofd low after nack rise")
        `WAITF(rx_valid_q)
        `CHK(rx_data_q, 8'hc3, "second reverse byte")
        @(posedge clk_sys) begin rev_en <= 1'b0; reverse_req <= 1'b0; end
        `WAITF(!reverse_q)
        tk();
        `CHK({nautofd_q, pd_oe_q}, 2'b11, "back to forward idle")
        $display("test ecp reverse done");
    endtask
    task automatic t_fault;
        @(posedge clk_sys) nfault <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nfault <= 1'b1;
        repeat (12) begin
            tk();
            `CHK(periph_req_q, 1'b0, "short nfault pulse dropped")
        end
        @(posedge clk_sys) nfault <= 1'b0;
        repeat (10) tk();
        `CHK(periph_req_q, 1'b1, "reversal request seen")
        @(posedge clk_sys) nfault <= 1'b1;
        repeat (10) tk();
        `CHK(periph_req_q, 1'b0, "reversal request gone")
        // leaving ecp from forward idle must fall back to open-collector drive
        @(posedge clk_sys) mode_sel <= 3'h0;
        repeat (3) tk();
        `CHK({totem_q, nstrobe_oe_q, nautofd_oe_q, nstrobe_q}, 4'h1, "open collector after ecp")
        $display("test fault done");
    endtask

    initial begin
        rst_n = 1'b0;
        mode_sel = 3'h0;
        reverse_req = 1'b0;
        transfer_direction_bit = 1'b1;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        rx_room = 1'b1;
        nfault = 1'b1;
        rev_en = 1'b0;
        slow = 1'b0;
        rev_byte = 8'h00;
        repeat (11) @(posedge clk_sys);
        #1;
        t_reset(1'b0);
        @(posedge clk_sys) rst_n <= 1'b1;
        tk();
        // forward data drivers turn on at the first edge after release
        t_reset(1'b1);
        t_dir();
        t_fifo();
        t_ecp_fwd();
        t_ecp_rev();
        t_fault();
        end_sim();
    end
endmodule // tb_top
